// ---- hw/iac_pkg.sv ----
// Purpose: constants and types for the abort cause and dma request block
// Assumes: byte addresses on a 32-bit AXI4-Lite bus, one word per register
// Notes:   all offsets, field positions and the dma, watermark, setup and control reset values live here
`default_nettype none

package iac_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_ABORT_CAUSE = 32'h5000_1580;
  localparam logic [31:0] ADDR_DMA_ENABLES = 32'h5000_1588;
  localparam logic [31:0] ADDR_TX_WMARK    = 32'h5000_158C;
  localparam logic [31:0] ADDR_RX_WMARK    = 32'h5000_1590;
  localparam logic [31:0] ADDR_SETUP_DELAY = 32'h5000_1594;
  localparam logic [31:0] ADDR_CONTROL     = 32'h5000_15C0;
  localparam logic [31:0] ADDR_IRQ_STATUS  = 32'h5000_15C4;
  localparam logic [31:0] ADDR_IRQ_MASK    = 32'h5000_15C8;

  // widths
  localparam int CAUSE_W = 16;
  localparam int LEVEL_W = 6;
  localparam int WMARK_W = 5;
  localparam int SETUP_W = 8;
  localparam int CTRL_W  = 5;
  localparam int IRQ_W   = 2;

  // abort cause bit positions
  localparam int CAUSE_SHORTADDR_NACK = 0;
  localparam int CAUSE_LONG1_NACK     = 1;
  localparam int CAUSE_LONG2_NACK     = 2;
  localparam int CAUSE_DATA_NACK      = 3;
  localparam int CAUSE_GCALL_NACK     = 4;
  localparam int CAUSE_GCALL_READ     = 5;
  localparam int CAUSE_HS_ACKED       = 6;
  localparam int CAUSE_SBYTE_ACKED    = 7;
  localparam int CAUSE_HS_NORESTART   = 8;
  localparam int CAUSE_SBYTE_NORST    = 9;
  localparam int CAUSE_LONGRD_NORST   = 10;
  localparam int CAUSE_BUS_LOST       = 12;
  localparam int CAUSE_SLAVE_FLUSH    = 13;
  localparam int CAUSE_SLAVE_LOST     = 14;
  // bits whose software clear beats a simultaneous set
  localparam logic [15:0] CAUSE_CLEAR_WINS = 16'h0200;

  // dma enable bits
  localparam int DMA_RX_ON = 0;
  localparam int DMA_TX_ON = 1;

  // control register bits
  localparam int CTRL_RESTART_ALLOW = 0;
  localparam int CTRL_CMD_SELECT_A  = 1;
  localparam int CTRL_GCALL_OR_SB   = 2;
  localparam int CTRL_LONG_ADDR     = 3;
  localparam int CTRL_HIGH_SPEED    = 4;

  // interrupt status / mask bits
  localparam int IRQ_ABORT    = 0;
  localparam int IRQ_BUS_LOST = 1;

  // reset values
  localparam logic [SETUP_W-1:0] SETUP_RESET = 8'h64;
  localparam logic [1:0]         DMA_RESET   = 2'h0;
  localparam logic [WMARK_W-1:0] WMARK_RESET = 5'h00;
  localparam logic [CTRL_W-1:0]  CTRL_RESET  = 5'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // kind of acknowledge slot announced by the bus sequencer
  typedef enum logic [2:0] {
    ACK_ADDR7       = 3'b000,
    ACK_ADDR10_ONE  = 3'b001,
    ACK_ADDR10_TWO  = 3'b010,
    ACK_DATA        = 3'b011,
    ACK_GCALL       = 3'b100,
    ACK_STARTBYTE   = 3'b101,
    ACK_HS_CODE     = 3'b110,
    ACK_NONE        = 3'b111
  } iac_ack_kind_t;

endpackage

`default_nettype wire

// ---- hw/iac_abort_dma.sv ----
// Purpose: transmit abort cause capture and fifo dma request generation
// Assumes: one clock i_clock, async high reset, bus sequencer on same clock
// Notes:   scl/sda pins are synchronised and sampled here for ack slots
`timescale 1ns/100ps
`default_nettype none

module iac_abort_dma
  import iac_pkg::*;
(
  // clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  // axi4-lite write address
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  // axi4-lite write data
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  // axi4-lite write response
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // axi4-lite read address
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [31:0]          s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  // axi4-lite read data
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  // bus pins, sampled only
  input  wire logic                 i_scl,
  input  wire logic                 i_sda,
  // bus sequencer status
  input  wire logic                 i_master_mode,
  input  wire logic                 i_master_start,
  input  wire logic                 i_cmd_read,
  input  wire logic                 i_cmd_pop,
  input  wire logic                 i_cmd_word_bit9,
  input  wire logic                 i_ack_phase,
  input  wire iac_ack_kind_t        i_ack_kind,
  input  wire logic                 i_bus_lost_flag,
  input  wire logic                 i_slv_bus_lost_flag,
  input  wire logic                 i_slv_read_req,
  // fifo levels
  input  wire logic [LEVEL_W-1:0]   i_tx_level,
  input  wire logic [LEVEL_W-1:0]   i_rx_level,
  // outputs to fifo, dma and cpu
  output logic                      o_tx_flush,
  output logic                      o_tx_dma_req,
  output logic                      o_rx_dma_req,
  output logic [SETUP_W-1:0]        o_setup_delay,
  output logic [CTRL_W-1:0]         o_control,
  output logic                      o_irq
);

  logic [CAUSE_W-1:0] cause;
  logic [CAUSE_W-1:0] next_set;
  logic [1:0]         dma_on;
  logic [WMARK_W-1:0] tx_wm;
  logic [WMARK_W-1:0] rx_wm;
  logic [SETUP_W-1:0] setup_delay;
  logic [CTRL_W-1:0]  ctrl;
  logic [IRQ_W-1:0]   irq_stat;
  logic [IRQ_W-1:0]   irq_mask;
  logic [2:0]         scl_sync;
  logic [1:0]         sda_sync;
  logic               scl_rise;
  logic               sda_high;
  logic               ack_eval;
  logic               restart_on;
  logic               gcall_mode;
  logic               sbyte_mode;
  logic               tx_pending;
  logic               aw_held;
  logic               w_held;
  logic [31:0]        aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               do_write;
  logic               lane0;
  logic               abort_ack;
  logic [31:0]        next_rdata;
  logic [1:0]         next_rresp;

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      scl_sync <= 3'h7;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[1:0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
    end
  end

  // scl rising edge and sampled data level
  assign scl_rise = scl_sync[1] & ~scl_sync[2];
  assign sda_high = sda_sync[1];
  assign ack_eval = scl_rise & i_ack_phase & i_master_mode;

  // configuration decodes
  assign restart_on = ctrl[CTRL_RESTART_ALLOW];
  assign gcall_mode = ctrl[CTRL_CMD_SELECT_A] & ~ctrl[CTRL_GCALL_OR_SB];
  assign sbyte_mode = ctrl[CTRL_CMD_SELECT_A] & ctrl[CTRL_GCALL_OR_SB];
  assign tx_pending = (i_tx_level != '0);

  // abort causes detected this cycle
  always_comb begin
    next_set = '0;
    next_set[CAUSE_LONGRD_NORST] = i_master_start & ~restart_on
      & ctrl[CTRL_LONG_ADDR] & i_cmd_read;
    next_set[CAUSE_SBYTE_NORST] = ~restart_on & sbyte_mode
      & tx_pending;
    next_set[CAUSE_HS_NORESTART] = i_master_start & ~restart_on
      & ctrl[CTRL_HIGH_SPEED];
    next_set[CAUSE_SBYTE_ACKED] = ack_eval
      & (i_ack_kind == ACK_STARTBYTE) & ~sda_high;
    next_set[CAUSE_HS_ACKED] = ack_eval
      & (i_ack_kind == ACK_HS_CODE) & ~sda_high;
    next_set[CAUSE_GCALL_READ] = i_master_mode & gcall_mode
      & i_cmd_pop & i_cmd_word_bit9;
    next_set[CAUSE_GCALL_NACK] = ack_eval
      & (i_ack_kind == ACK_GCALL) & sda_high;
    next_set[CAUSE_DATA_NACK] = ack_eval
      & (i_ack_kind == ACK_DATA) & sda_high;
    next_set[CAUSE_LONG2_NACK] = ack_eval
      & (i_ack_kind == ACK_ADDR10_TWO) & sda_high;
    next_set[CAUSE_LONG1_NACK] = ack_eval
      & (i_ack_kind == ACK_ADDR10_ONE) & sda_high;
    next_set[CAUSE_SHORTADDR_NACK] = ack_eval
      & (i_ack_kind == ACK_ADDR7) & sda_high;
    next_set[CAUSE_BUS_LOST] = i_bus_lost_flag | i_slv_bus_lost_flag;
    next_set[CAUSE_SLAVE_LOST] = i_slv_bus_lost_flag;
    next_set[CAUSE_SLAVE_FLUSH] = i_slv_read_req & tx_pending;
  end

  // abort cause register; set wins over clear except where noted
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cause <= '0;
    end else if (abort_ack) begin
      cause <= next_set & ~CAUSE_CLEAR_WINS;
    end else begin
      cause <= cause | next_set;
    end
  end

  // sticky event bits, cleared by writing one
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      irq_stat <= '0;
    end else begin
      irq_stat[IRQ_ABORT] <= (|next_set)
        | (irq_stat[IRQ_ABORT] & ~abort_ack);
      irq_stat[IRQ_BUS_LOST] <= next_set[CAUSE_BUS_LOST]
        | (irq_stat[IRQ_BUS_LOST]
           & ~(do_write && aw_addr == ADDR_IRQ_STATUS && lane0
               && w_data[IRQ_BUS_LOST]));
    end
  end

  // registered outputs: flush, dma requests and interrupt
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_tx_flush   <= 1'b0;
      o_tx_dma_req <= 1'b0;
      o_rx_dma_req <= 1'b0;
      o_irq        <= 1'b0;
    end else begin
      o_tx_flush   <= irq_stat[IRQ_ABORT];
      o_tx_dma_req <= dma_on[DMA_TX_ON]
        && ({1'b0, tx_wm} >= i_tx_level);
      o_rx_dma_req <= dma_on[DMA_RX_ON]
        && (i_rx_level >= ({1'b0, rx_wm} + 6'h01));
      o_irq        <= |(irq_stat & irq_mask);
    end
  end

  // write channel capture; address and data taken in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign do_write      = aw_held & w_held & ~s_axi_bvalid;
  assign lane0         = w_strb[0];
  assign abort_ack     = do_write && aw_addr == ADDR_IRQ_STATUS
                         && lane0 && w_data[IRQ_ABORT];

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        ADDR_ABORT_CAUSE, ADDR_DMA_ENABLES, ADDR_TX_WMARK,
        ADDR_RX_WMARK, ADDR_SETUP_DELAY, ADDR_CONTROL,
        ADDR_IRQ_STATUS, ADDR_IRQ_MASK: s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // software written configuration, all in byte lane 0
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      dma_on      <= DMA_RESET;
      tx_wm       <= WMARK_RESET;
      rx_wm       <= WMARK_RESET;
      setup_delay <= SETUP_RESET;
      ctrl        <= CTRL_RESET;
      irq_mask    <= '0;
    end else if (do_write && lane0) begin
      case (aw_addr)
        ADDR_DMA_ENABLES: dma_on      <= w_data[1:0];
        ADDR_TX_WMARK:    tx_wm       <= w_data[WMARK_W-1:0];
        ADDR_RX_WMARK:    rx_wm       <= w_data[WMARK_W-1:0];
        ADDR_SETUP_DELAY: setup_delay <= w_data[SETUP_W-1:0];
        ADDR_CONTROL:     ctrl        <= w_data[CTRL_W-1:0];
        ADDR_IRQ_MASK:    irq_mask    <= w_data[IRQ_W-1:0];
        default:          ctrl        <= ctrl;
      endcase
    end
  end

  assign o_setup_delay = setup_delay;
  assign o_control     = ctrl;

  // read data selection; reserved bits read zero
  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    case (s_axi_araddr)
      ADDR_ABORT_CAUSE: next_rdata[CAUSE_W-1:0] = cause;
      ADDR_DMA_ENABLES: next_rdata[1:0] = dma_on;
      ADDR_TX_WMARK:    next_rdata[WMARK_W-1:0] = tx_wm;
      ADDR_RX_WMARK:    next_rdata[WMARK_W-1:0] = rx_wm;
      ADDR_SETUP_DELAY: next_rdata[SETUP_W-1:0] = setup_delay;
      ADDR_CONTROL:     next_rdata[CTRL_W-1:0] = ctrl;
      ADDR_IRQ_STATUS:  next_rdata[IRQ_W-1:0] = irq_stat;
      ADDR_IRQ_MASK:    next_rdata[IRQ_W-1:0] = irq_mask;
      default:          next_rresp = RESP_SLVERR;
    endcase
  end

  // read channel: one read at a time
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks on the captured causes and requests
  property p_longrd;
    @(posedge i_clock) disable iff (i_rst)
    (i_master_start && !restart_on && ctrl[CTRL_LONG_ADDR] && i_cmd_read)
      |=> cause[CAUSE_LONGRD_NORST] ##1 cause[CAUSE_LONGRD_NORST];
  endproperty
  a_longrd: assert property (p_longrd)
    else $error("10-bit read without restart not flagged");

  property p_sbyte_reassert;
    @(posedge i_clock) disable iff (i_rst)
    (abort_ack && !restart_on && sbyte_mode && tx_pending
      && $stable(ctrl))
      |=> !cause[CAUSE_SBYTE_NORST] ##1 cause[CAUSE_SBYTE_NORST];
  endproperty
  a_sbyte_reassert: assert property (p_sbyte_reassert)
    else $error("start byte cause did not drop then return");

  property p_addr7_nack;
    @(posedge i_clock) disable iff (i_rst)
    (ack_eval && i_ack_kind == ACK_ADDR7 && sda_high)
      |=> cause[CAUSE_SHORTADDR_NACK] && irq_stat[IRQ_ABORT];
  endproperty
  a_addr7_nack: assert property (p_addr7_nack)
    else $error("7-bit address nack not flagged");

  property p_slave_lost;
    @(posedge i_clock) disable iff (i_rst)
    i_slv_bus_lost_flag |=> cause[CAUSE_BUS_LOST] && cause[CAUSE_SLAVE_LOST];
  endproperty
  a_slave_lost: assert property (p_slave_lost)
    else $error("slave bus loss missing bit 12 or 14");

  property p_flush;
    @(posedge i_clock) disable iff (i_rst)
    (i_slv_read_req && tx_pending)
      |=> cause[CAUSE_SLAVE_FLUSH] ##1 o_tx_flush;
  endproperty
  a_flush: assert property (p_flush)
    else $error("slave read with tx data did not flush");

  property p_abort_held;
    @(posedge i_clock) disable iff (i_rst)
    (|next_set) ##1 (!abort_ack)[*2] |-> o_tx_flush;
  endproperty
  a_abort_held: assert property (p_abort_held)
    else $error("abort event not held until acknowledged");

  property p_tx_dma;
    @(posedge i_clock) disable iff (i_rst)
    ##1 (o_tx_dma_req == ($past(dma_on[DMA_TX_ON])
      && ($past(i_tx_level) <= {1'b0, $past(tx_wm)})));
  endproperty
  a_tx_dma: assert property (p_tx_dma)
    else $error("tx dma request wrong for level");

  property p_rx_dma;
    @(posedge i_clock) disable iff (i_rst)
    ##1 (o_rx_dma_req == ($past(dma_on[DMA_RX_ON])
      && ($past(i_rx_level) > {1'b0, $past(rx_wm)})));
  endproperty
  a_rx_dma: assert property (p_rx_dma)
    else $error("rx dma request wrong for level");

  property p_data_nack;
    @(posedge i_clock) disable iff (i_rst)
    (!i_master_mode && !cause[CAUSE_DATA_NACK] && !abort_ack)
      |=> !cause[CAUSE_DATA_NACK];
  endproperty
  a_data_nack: assert property (p_data_nack)
    else $error("data nack flagged outside master mode");

endmodule // iac_abort_dma

`default_nettype wire

// ---- verification/iac_far_model.sv ----
// Purpose: remote bus party that answers one acknowledge slot on request
// Assumes: open-drain lines with pull-ups, so released lines read high
// Notes:   scl runs only inside a slot, 200 ns period, idle high
`timescale 1ns/100ps
`default_nettype none

module iac_far_model (
  // request from the bench
  input  wire logic i_go,
  input  wire logic i_ack,
  // bus lines and progress
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_busy
);
  // idle lines sit at the pull-up level
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_busy = 1'b0;
  end

  // one low-high-low clock period with the answer held on sda
  // edges fall between system clock edges; busy ends with scl low so
  // the closing rise back to idle lands after the slot is closed
  always @(posedge i_go) begin
    o_busy = 1'b1;
    #40 o_scl = 1'b0;
    o_sda = !i_ack;  // low means acknowledge
    #100 o_scl = 1'b1;
    #100 o_scl = 1'b0;
    o_sda = 1'b1;  // released, the pull-up wins
    o_busy = 1'b0;
    #100 o_scl = 1'b1;
  end
endmodule // iac_far_model

`default_nettype wire

// ---- verification/iac_abort_dma_bench.sv ----
// Purpose: self-checking bench for the abort cause and dma request block
// Assumes: far model drives the bus pins, bench drives sequencer and bus
// Notes:   random dma levels from a fixed seed, abort cases from tables
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t got %h want %h", $time, a, b); end end

module iac_abort_dma_bench;
  import iac_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic scl, sda, busy, irq, flush, txreq, rxreq, mask_on;
  logic mmode = 1'b0, mstart = 1'b0, cread = 1'b1, cpop = 1'b0;
  logic cbit9 = 1'b1, aphase = 1'b0, arb = 1'b0, sarb = 1'b0;
  logic srd = 1'b0, go = 1'b0, ackv = 1'b0;
  iac_ack_kind_t akind = ACK_NONE;
  logic [LEVEL_W-1:0] txl = '0, rxl = '0;
  logic [SETUP_W-1:0] setup;
  logic [CTRL_W-1:0]  ctrl;
  logic [31:0] v;
  int n_fail = 0;
  int cmp_count = 0;
  // abort tables: control, event, expected cause / slot kind, ack, cause
  logic [7:0]  ev_ctl [10] = '{8'h08, 8'h09, 8'h10, 8'h11, 8'h02,
                               8'h07, 8'h01, 8'h01, 8'h01, 8'h01};
  int          ev_src [10] = '{0, 0, 0, 0, 1, 1, 2, 3, 4, 4};
  logic [31:0] ev_exp [10] = '{32'h400, 32'h0, 32'h100, 32'h0, 32'h20,
                               32'h0, 32'h1000, 32'h5000, 32'h2000, 32'h0};
  logic [2:0]  sl_kind [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6,
                               3'h0};
  logic        sl_ack [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
                              1'b1};
  logic [31:0] sl_exp [8] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h80,
                              32'h40, 32'h0};

  // design under test
  iac_abort_dma dut_u (
    .i_clock(i_clock), .i_rst(i_rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .i_scl(scl), .i_sda(sda), .i_master_mode(mmode),
    .i_master_start(mstart), .i_cmd_read(cread), .i_cmd_pop(cpop),
    .i_cmd_word_bit9(cbit9), .i_ack_phase(aphase), .i_ack_kind(akind),
    .i_bus_lost_flag(arb), .i_slv_bus_lost_flag(sarb), .i_slv_read_req(srd),
    .i_tx_level(txl), .i_rx_level(rxl), .o_tx_flush(flush),
    .o_tx_dma_req(txreq), .o_rx_dma_req(rxreq), .o_setup_delay(setup),
    .o_control(ctrl), .o_irq(irq)
  );

  // remote party on the bus pins
  iac_far_model far_u (
    .i_go(go), .i_ack(ackv), .o_scl(scl), .o_sda(sda), .o_busy(busy)
  );

  // 40 MHz clock
  initial begin
    forever #12.5 i_clock = ~i_clock;
  end

  // hang guard, far beyond the expected run length
  initial begin
    #2000000;
    n_fail++;
    give_verdict();
  end

  task automatic tick(input int k);
    repeat (k) @(posedge i_clock);
  endtask

  // one write: address and data offered together, response awaited
  task automatic axw(input logic [31:0] a, d, input logic [1:0] r);
    int n;
    logic ad, wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd) && n < 99) begin
      @(posedge i_clock);
      n++;
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge i_clock);
      n++;
    end while (!bvalid && n < 99);
    if (n >= 99) n_fail++;  // lost response; bready stays up
    `CHK(bresp, r)
  endtask

  // one read: data and response taken at the edge rvalid is seen
  task automatic axr(input logic [31:0] a, output logic [31:0] d,
                     input logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (!arready && n < 99);
    arvalid <= 1'b0;
    do begin
      @(posedge i_clock);
      n++;
    end while (!rvalid && n < 99);
    d = rdata;
    if (n >= 99) n_fail++;  // lost read data; rready stays up
    `CHK(rresp, r)
  endtask

  // pulse one sequencer event for a single cycle
  task automatic fire(input int w);
    case (w)
      0: mstart <= 1'b1;
      1: cpop <= 1'b1;
      2: arb <= 1'b1;
      3: sarb <= 1'b1;
      default: srd <= 1'b1;
    endcase
    tick(1);
    {mstart, cpop, arb, sarb, srd} <= 5'h00;
  endtask

  // check the captured cause, flush and interrupt, then acknowledge
  task automatic cause_case(input logic [31:0] e);
    logic [31:0] c;
    tick(4);
    axr(ADDR_ABORT_CAUSE, c, RESP_OKAY);
    `CHK(c, e)
    `CHK(flush, e != 0)
    `CHK(irq, mask_on && e != 0)
    axr(ADDR_IRQ_STATUS, c, RESP_OKAY);
    `CHK(c, (e[12] ? 32'h2 : 32'h0) | 32'(e != 0))
    axw(ADDR_IRQ_STATUS, 32'h3, RESP_OKAY);
    axr(ADDR_ABORT_CAUSE, c, RESP_OKAY);
    `CHK(c, 32'h0)
  endtask

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [1:0] en;
    logic [4:0] tw, rw;
    logic [5:0] tl, rl;
    void'($urandom(32'h1B4C));
    mask_on = 1'b0;
    tick(20);
    i_rst <= 1'b0;
    tick(1);
    // reset values, read-only cause, unmapped place
    axw(ADDR_ABORT_CAUSE, 32'hFFFF, RESP_OKAY);
    axw(32'h5000_1584, 32'h1, RESP_SLVERR);
    axr(32'h5000_1584, v, RESP_SLVERR);
    `CHK(v, 32'h0)
    axr(ADDR_SETUP_DELAY, v, RESP_OKAY);
    `CHK(v, 32'h64)
    foreach (ev_src[i]) begin
      if (i < 4) begin
        axr(ADDR_ABORT_CAUSE + 32'(i) * 32'h4 + 32'h4 * 32'(i > 0), v,
            RESP_OKAY);
        `CHK(v, 32'h0)
      end
    end
    axw(ADDR_SETUP_DELAY, 32'hAB, RESP_OKAY);
    axr(ADDR_SETUP_DELAY, v, RESP_OKAY);
    `CHK(v, 32'hAB)
    `CHK(setup, 8'hAB)
    // dma requests against random and boundary levels
    for (int i = 0; i < 40; i++) begin
      en = 2'($urandom);
      tw = 5'($urandom);
      rw = 5'($urandom);
      tl = (i % 2) ? 6'(tw) + 6'(i % 4 == 1) : 6'($urandom);
      rl = (i % 2) ? 6'(rw) + 6'(i % 4 == 1) : 6'($urandom);
      axw(ADDR_DMA_ENABLES, 32'(en), RESP_OKAY);
      axw(ADDR_TX_WMARK, 32'(tw), RESP_OKAY);
      axw(ADDR_RX_WMARK, 32'(rw), RESP_OKAY);
      txl <= tl;
      rxl <= rl;
      tick(2);
      `CHK(txreq, en[1] && tl <= 6'(tw))
      `CHK(rxreq, en[0] && rl >= 6'(rw) + 6'd1)
    end
    // sequencer events, interrupt masked for the first one only
    mmode <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      if (i == 1) begin
        axw(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
        mask_on = 1'b1;
      end
      axw(ADDR_CONTROL, 32'(ev_ctl[i]), RESP_OKAY);
      `CHK(ctrl, ev_ctl[i][4:0])
      txl <= (i == 9) ? 6'h00 : 6'h03;
      tick(1);
      fire(ev_src[i]);
      cause_case(ev_exp[i]);
    end
    // acknowledge slots answered by the far side
    for (int i = 0; i < 8; i++) begin
      aphase <= 1'b1;
      akind <= iac_ack_kind_t'(sl_kind[i]);
      ackv <= sl_ack[i];
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      while (busy) tick(1);
      aphase <= 1'b0;
      akind <= ACK_NONE;
      cause_case(sl_exp[i]);
    end
    // start byte with restart off, cleared before and after the fix
    txl <= 6'h03;
    axw(ADDR_CONTROL, 32'h06, RESP_OKAY);
    tick(4);
    axr(ADDR_ABORT_CAUSE, v, RESP_OKAY);
    `CHK(v, 32'h200)
    axw(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
    axr(ADDR_ABORT_CAUSE, v, RESP_OKAY);
    `CHK(v, 32'h200)
    axw(ADDR_CONTROL, 32'h07, RESP_OKAY);
    axw(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
    axr(ADDR_ABORT_CAUSE, v, RESP_OKAY);
    `CHK(v, 32'h0)
    give_verdict();
  end
endmodule // iac_abort_dma_bench

`default_nettype wire
